// ===== src/fifo_regs.svh
/*
  Constants for the dual-clock flagged FIFO: widths, depth, offset portion bounds
  and reset values of the threshold offsets.
  Assumes it is included by bare name from the package and the core.
*/
`ifndef FIFO_REGS_SVH
`define FIFO_REGS_SVH

// ----------------------------------------------------------------------
// widths and depth
// ----------------------------------------------------------------------
`define FIFO_DW 9
`define FIFO_AW 14
`define FIFO_PW 15
`define FIFO_DEPTH 15'h4000
`define FIFO_HI_W 5

// ----------------------------------------------------------------------
// offset portions and reset values
// ----------------------------------------------------------------------
`define FIFO_LO_MSB 8
`define FIFO_HI_LSB 9
`define FIFO_EMPTY_OFF_RST 14'h0007
`define FIFO_FULL_OFF_RST 14'h0007

`endif

// ===== src/fifo_pkg.sv
/*
  Types shared by the dual-clock flagged FIFO core.
  Assumes fifo_regs.svh supplies the widths.
*/
`include "fifo_regs.svh"

package fifo_pkg;

  // ----------------------------------------------------------------------
  // basic words
  // ----------------------------------------------------------------------
  typedef logic [`FIFO_DW-1:0] word_t;
  typedef logic [`FIFO_PW-1:0] ptr_t;
  typedef logic [`FIFO_AW-1:0] off_t;

  // offset portion sequence
  typedef enum logic [1:0] {STEP_EMPTY_LO, STEP_EMPTY_HI, STEP_FULL_LO, STEP_FULL_HI} off_step_e;

  // ----------------------------------------------------------------------
  // pin groups and domain state
  // ----------------------------------------------------------------------
  typedef struct packed {
    word_t word;
    logic en_a_n;
    logic en_b_ld_n;
  } wr_pins_s;

  typedef struct packed {
    logic en_a_n;
    logic en_b_n;
    logic ld_n;
    logic oe_n;
  } rd_pins_s;

  typedef struct packed {
    wr_pins_s p1;
    wr_pins_s p2;
    logic two_en;
    ptr_t wptr;
    ptr_t wgray;
    ptr_t rg1;
    ptr_t rg2;
    logic full_n;
    logic near_full_n;
    off_t empty_off;
    off_t full_off;
    off_step_e step;
    logic tgl;
  } wr_state_s;

  typedef struct packed {
    logic rst1;
    logic rst2;
    rd_pins_s p1;
    rd_pins_s p2;
    logic mode1;
    logic mode2;
    ptr_t wg1;
    ptr_t wg2;
    logic tg1;
    logic tg2;
    logic seen;
    ptr_t rptr;
    ptr_t rgray;
    logic empty_n;
    logic near_empty_n;
    off_t empty_off;
    off_t full_off;
    off_step_e step;
    word_t word;
    logic oe_n;
  } rd_state_s;

endpackage

// ===== src/dual_clock_flagged_fifo.sv
/*
  Dual-clock 9-bit FIFO with empty, full, near-empty and near-full flags,
  a dual-purpose write enable / offset load pin and an output enable passed out beside an always-driven word.
  Assumes clk_in is the write clock, read_clk_in the free-running read
  clock, and that all pins arrive asynchronously to both.
*/
// How it works
// - both data ports are nine bits, one word per accepted edge
// - in offset mode write needs A low, load high, not full
// - in two-enable mode write needs A low, B high, not full
// - dual pin sampled during reset picks two-enable or offset-load mode
// - writes while full change neither storage nor write pointer
// - load asserted: qualifying write edge stores word into offset register
// - load low: qualifying read edge drives offset register onto output
// - read advances only with both read enables low and not empty
// - empty flag low when no words, updated on read clock only
// - full flag low at capacity, updated on write clock only
// - near-empty low when fill falls to programmed offset, read clock
// - near-full low within programmed offset of capacity, write clock
// - reset clears pointers, flags show empty and not full
// - output enable pin passed out on read_word_oe_n_out; read word always driven
// - offsets reset to seven, each programmed as a low and a high word
// - after reset the output shows all zeros
// - first word readable the read cycle after empty rises
`include "fifo_regs.svh"

module dual_clock_flagged_fifo (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic read_clk_in,
  input wire fifo_pkg::word_t write_word_in,
  input wire logic write_enable_a_n_in,
  input wire logic write_enable_b_or_load_n_in,
  input wire logic read_enable_a_n_in,
  input wire logic read_enable_b_n_in,
  input wire logic output_enable_n_in,
  output fifo_pkg::word_t read_word_out,
  output logic read_word_oe_n_out,
  output logic empty_indicator_n_out,
  output logic full_indicator_n_out,
  output logic near_empty_indicator_n_out,
  output logic near_full_indicator_n_out
);
  import fifo_pkg::*;

  // ----------------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------------
  wr_state_s w_q, w_d;
  rd_state_s r_q, r_d;
  word_t mem [0:(1<<`FIFO_AW)-1];
  logic store;
  logic load;
  logic rd_rst;
  logic rd_ok;
  logic rd_fire;
  logic off_fire;
  ptr_t rbin_w;
  ptr_t wbin_r;
  ptr_t wnext;
  ptr_t rnext;
  ptr_t cnt_w;
  ptr_t cnt_r;

  // gray to binary for synced pointers
  function automatic ptr_t g2b(input ptr_t g);
    ptr_t b;
    b[`FIFO_PW-1] = g[`FIFO_PW-1];
    for (int i = `FIFO_PW-2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // write domain
  // ----------------------------------------------------------------------
  // write qualifiers from the second sync stage only
  always_comb
  begin
    if (w_q.two_en)
    begin
      store = !w_q.p2.en_a_n && w_q.p2.en_b_ld_n && w_q.full_n;
      load = 1'b0;
    end
    else
    begin
      store = !w_q.p2.en_a_n && w_q.p2.en_b_ld_n && w_q.full_n;
      load = !w_q.p2.en_a_n && !w_q.p2.en_b_ld_n;
    end
  end

  // write pointer, full flags, offset loads
  always_comb
  begin
    w_d = w_q;
    w_d.p1 = '{word: write_word_in, en_a_n: write_enable_a_n_in, en_b_ld_n: write_enable_b_or_load_n_in};
    w_d.p2 = w_q.p1;
    // read pointer crosses as gray code
    w_d.rg1 = r_q.rgray;
    w_d.rg2 = w_q.rg1;
    rbin_w = g2b(w_q.rg2);
    // pointer only moves on a store
    wnext = store ? w_q.wptr + 15'h0001 : w_q.wptr;
    cnt_w = wnext - rbin_w;
    if (reset_in)
    begin
      // strap caught while reset is held
      w_d.two_en = w_q.p2.en_b_ld_n;
      w_d.wptr = '0;
      w_d.wgray = '0;
      w_d.full_n = 1'b1;
      w_d.near_full_n = 1'b1;
      w_d.empty_off = `FIFO_EMPTY_OFF_RST;
      w_d.full_off = `FIFO_FULL_OFF_RST;
      w_d.step = STEP_EMPTY_LO;
      w_d.tgl = 1'b0;
    end
    else
    begin
      w_d.wptr = wnext;
      w_d.wgray = wnext ^ (wnext >> 1);
      w_d.full_n = (cnt_w != `FIFO_DEPTH);
      w_d.near_full_n = (cnt_w < (`FIFO_DEPTH - ptr_t'(w_q.full_off)));
      // load goes to the offset register
      if (load)
      begin
        case (w_q.step)
          STEP_EMPTY_LO: w_d.empty_off[`FIFO_LO_MSB:0] = w_q.p2.word;
          STEP_EMPTY_HI: w_d.empty_off[`FIFO_AW-1:`FIFO_HI_LSB] = w_q.p2.word[`FIFO_HI_W-1:0];
          STEP_FULL_LO: w_d.full_off[`FIFO_LO_MSB:0] = w_q.p2.word;
          STEP_FULL_HI: w_d.full_off[`FIFO_AW-1:`FIFO_HI_LSB] = w_q.p2.word[`FIFO_HI_W-1:0];
          default: w_d.empty_off = w_q.empty_off;
        endcase
        w_d.step = off_step_e'(w_q.step + 2'h1);
        w_d.tgl = !w_q.tgl;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    w_q <= w_d;
  end

  // storage write, kept out of the state record
  always_ff @(posedge clk_in)
  begin
    if (store && !reset_in)
    begin
      mem[w_q.wptr[`FIFO_AW-1:0]] <= w_q.p2.word;
    end
  end

  // ----------------------------------------------------------------------
  // read domain
  // ----------------------------------------------------------------------
  // read qualifiers; offset reads steal the port in load mode
  always_comb
  begin
    rd_rst = r_q.rst2;
    rd_ok = !r_q.p2.en_a_n && !r_q.p2.en_b_n;
    off_fire = rd_ok && !r_q.mode2 && !r_q.p2.ld_n;
    // both enables low and not empty
    // empty flag gates the first read
    rd_fire = rd_ok && r_q.empty_n && !off_fire;
  end

  // read pointer, empty flags, output word
  always_comb
  begin
    r_d = r_q;
    r_d.rst1 = reset_in;
    r_d.rst2 = r_q.rst1;
    r_d.p1 = '{en_a_n: read_enable_a_n_in, en_b_n: read_enable_b_n_in, ld_n: write_enable_b_or_load_n_in,
               oe_n: output_enable_n_in};
    r_d.p2 = r_q.p1;
    r_d.mode1 = w_q.two_en;
    r_d.mode2 = r_q.mode1;
    // write pointer crosses as gray code
    r_d.wg1 = w_q.wgray;
    r_d.wg2 = r_q.wg1;
    r_d.tg1 = w_q.tgl;
    r_d.tg2 = r_q.tg1;
    wbin_r = g2b(r_q.wg2);
    rnext = rd_fire ? r_q.rptr + 15'h0001 : r_q.rptr;
    cnt_r = wbin_r - rnext;
    r_d.oe_n = r_q.p2.oe_n;
    if (rd_rst)
    begin
      r_d.rptr = '0;
      r_d.rgray = '0;
      r_d.empty_n = 1'b0;
      r_d.near_empty_n = 1'b0;
      r_d.empty_off = `FIFO_EMPTY_OFF_RST;
      r_d.full_off = `FIFO_FULL_OFF_RST;
      r_d.seen = 1'b0;
      r_d.step = STEP_EMPTY_LO;
      r_d.word = '0;
    end
    else
    begin
      r_d.rptr = rnext;
      r_d.rgray = rnext ^ (rnext >> 1);
      // empty when no words, read clock
      r_d.empty_n = (cnt_r != '0);
      r_d.near_empty_n = (cnt_r > ptr_t'(r_q.empty_off));
      // copy offsets while the synced toggle sits still; edge-only copies miss an even burst of loads
      r_d.seen = r_q.tg2;
      if (r_q.tg2 == r_q.seen)
      begin
        r_d.empty_off = w_q.empty_off;
        r_d.full_off = w_q.full_off;
      end
      if (rd_fire)
      begin
        r_d.word = mem[r_q.rptr[`FIFO_AW-1:0]];
      end
      else if (off_fire)
      begin
        case (r_q.step)
          STEP_EMPTY_LO: r_d.word = r_q.empty_off[`FIFO_LO_MSB:0];
          STEP_EMPTY_HI: r_d.word = word_t'(r_q.empty_off[`FIFO_AW-1:`FIFO_HI_LSB]);
          STEP_FULL_LO: r_d.word = r_q.full_off[`FIFO_LO_MSB:0];
          STEP_FULL_HI: r_d.word = word_t'(r_q.full_off[`FIFO_AW-1:`FIFO_HI_LSB]);
          default: r_d.word = r_q.word;
        endcase
        // read portions in the same order
        r_d.step = off_step_e'(r_q.step + 2'h1);
      end
    end
  end

  always_ff @(posedge read_clk_in)
  begin
    r_q <= r_d;
  end

  // ----------------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------------
  assign read_word_out = r_q.word;
  assign read_word_oe_n_out = r_q.oe_n;
  assign empty_indicator_n_out = r_q.empty_n;
  assign near_empty_indicator_n_out = r_q.near_empty_n;
  assign full_indicator_n_out = w_q.full_n;
  assign near_full_indicator_n_out = w_q.near_full_n;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_store;
    store;
  endsequence
  sequence s_load;
    load;
  endsequence

  property p_store_adv;
    @(posedge clk_in) disable iff (reset_in) s_store |=> w_q.wptr == $past(w_q.wptr) + 15'h0001;
  endproperty
  a_store_adv: assert property (p_store_adv) else $error("write pointer did not advance");

  property p_full_hold;
    @(posedge clk_in) disable iff (reset_in) !w_q.full_n |=> w_q.wptr == $past(w_q.wptr);
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("pointer moved while full");

  property p_full_flag;
    @(posedge clk_in) disable iff (reset_in)
      !$past(reset_in) |-> (!w_q.full_n == ((w_q.wptr - g2b($past(w_q.rg2))) == `FIFO_DEPTH));
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag disagrees with fill");

  property p_near_full;
    @(posedge clk_in) disable iff (reset_in) !$past(reset_in) |->
      (w_q.near_full_n == ((w_q.wptr - g2b($past(w_q.rg2))) < (`FIFO_DEPTH - ptr_t'($past(w_q.full_off)))));
  endproperty
  a_near_full: assert property (p_near_full) else $error("near-full flag wrong");

  property p_load_step;
    @(posedge clk_in) disable iff (reset_in) s_load |=> w_q.step == off_step_e'($past(w_q.step) + 2'h1) ##1 1'b1;
  endproperty
  a_load_step: assert property (p_load_step) else $error("offset portion did not step");

  property p_reset_state;
    @(posedge clk_in) reset_in |=> w_q.wptr == '0 && w_q.full_n && w_q.empty_off == `FIFO_EMPTY_OFF_RST;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_rd_adv;
    @(posedge read_clk_in) disable iff (rd_rst)
      rd_fire |=> r_q.rptr == $past(r_q.rptr) + 15'h0001 && r_q.word == $past(mem[r_q.rptr[`FIFO_AW-1:0]]);
  endproperty
  a_rd_adv: assert property (p_rd_adv) else $error("read did not deliver next word");

  property p_rd_hold;
    @(posedge read_clk_in) disable iff (rd_rst) !rd_fire && !off_fire |=> $stable(r_q.word) && $stable(r_q.rptr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("output changed without a read");

  property p_empty_flag;
    @(posedge read_clk_in) disable iff (rd_rst)
      !$past(rd_rst) |-> (!r_q.empty_n == (g2b($past(r_q.wg2)) == r_q.rptr));
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag disagrees with fill");

  property p_near_empty;
    @(posedge read_clk_in) disable iff (rd_rst) !$past(rd_rst) |->
      (r_q.near_empty_n == ((g2b($past(r_q.wg2)) - r_q.rptr) > ptr_t'($past(r_q.empty_off))));
  endproperty
  a_near_empty: assert property (p_near_empty) else $error("near-empty flag wrong");

  property p_oe_follow;
    @(posedge read_clk_in) disable iff (rd_rst)
      !$past(rd_rst) |-> read_word_oe_n_out == $past(r_q.p2.oe_n);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("output enable not tracking pin");

endmodule

// ===== verif/fifo_partner.sv
/*
  Producer and consumer model for the FIFO pins.
  Assumes the bench calls its tasks and supplies both clocks.
*/
module fifo_partner (
  input wire logic clk_in,
  input wire logic read_clk_in,
  input wire fifo_pkg::word_t read_word_in,
  output fifo_pkg::word_t write_word_out,
  output logic write_enable_a_n_out,
  output logic write_enable_b_or_load_n_out,
  output logic read_enable_a_n_out,
  output logic read_enable_b_n_out,
  output logic output_enable_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import fifo_pkg::*;

  // idle pins before reset
  initial
  begin
    write_word_out = 9'h000;
    write_enable_a_n_out = 1'b1;
    write_enable_b_or_load_n_out = 1'b1;
    read_enable_a_n_out = 1'b1;
    read_enable_b_n_out = 1'b1;
    output_enable_n_out = 1'b0;
  end

  task automatic push(input int n, input word_t base);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_in);
      #1;
      write_enable_a_n_out = 1'b0;
      write_enable_b_or_load_n_out = 1'b1;
      write_word_out = base + word_t'(i);
    end
    @(posedge clk_in);
    #1;
    write_enable_a_n_out = 1'b1;
    // idle data is scrambled so a stale word never looks fresh
    write_word_out = ~write_word_out;
  endtask

  task automatic load(input word_t w);
    @(posedge clk_in);
    #1;
    write_enable_a_n_out = 1'b0;
    write_enable_b_or_load_n_out = 1'b0;
    write_word_out = w;
    @(posedge clk_in);
    #1;
    write_enable_a_n_out = 1'b1;
    write_enable_b_or_load_n_out = 1'b1;
    write_word_out = ~w;
  endtask

  // one read cycle; the pins pass two sync flops before acting
  task automatic pull(input logic b_n, output word_t w);
    @(posedge read_clk_in);
    #1;
    read_enable_a_n_out = 1'b0;
    read_enable_b_n_out = b_n;
    @(posedge read_clk_in);
    #1;
    read_enable_a_n_out = 1'b1;
    read_enable_b_n_out = 1'b1;
    @(posedge read_clk_in);
    @(posedge read_clk_in);
    #1;
    w = read_word_in;
  endtask
endmodule

// ===== verif/dual_clock_flagged_fifo_tb.sv
/*
  Self-checking bench for the dual-clock flagged FIFO.
  Assumes fifo_partner drives all pins but reset_in; write clock 4 ns, read clock 80 ns.
*/
module dual_clock_flagged_fifo_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fifo_pkg::*;

  logic clk_in;
  logic read_clk_in;
  logic reset_in;
  word_t wr_word;
  word_t rd_word;
  logic wr_a_n, wr_b_ld_n, rd_a_n, rd_b_n, oe_n, rd_oe_n;
  logic empty_n, full_n, near_empty_n, near_full_n;
  int n_errors;
  int samples_checked;

  // ----------------------------------------------------------------------
  // clocks, unrelated in phase
  // ----------------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial
  begin
    read_clk_in = 1'b0;
    #7.3;
    forever #40 read_clk_in = ~read_clk_in;
  end

  fifo_partner partner_inst (
    .clk_in(clk_in),
    .read_clk_in(read_clk_in),
    .read_word_in(rd_word),
    .write_word_out(wr_word),
    .write_enable_a_n_out(wr_a_n),
    .write_enable_b_or_load_n_out(wr_b_ld_n),
    .read_enable_a_n_out(rd_a_n),
    .read_enable_b_n_out(rd_b_n),
    .output_enable_n_out(oe_n)
  );

  dual_clock_flagged_fifo dual_clock_flagged_fifo_inst (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .read_clk_in(read_clk_in),
    .write_word_in(wr_word),
    .write_enable_a_n_in(wr_a_n),
    .write_enable_b_or_load_n_in(wr_b_ld_n),
    .read_enable_a_n_in(rd_a_n),
    .read_enable_b_n_in(rd_b_n),
    .output_enable_n_in(oe_n),
    .read_word_out(rd_word),
    .read_word_oe_n_out(rd_oe_n),
    .empty_indicator_n_out(empty_n),
    .full_indicator_n_out(full_n),
    .near_empty_indicator_n_out(near_empty_n),
    .near_full_indicator_n_out(near_full_n)
  );

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input word_t got, input word_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait; flags cross late, so allow twenty read clocks
  task automatic wait_flag(input int sel, input logic v);
    logic f;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge clk_in);
      #1;
      f = (sel == 0) ? empty_n : (sel == 1) ? full_n : (sel == 2) ? near_empty_n : near_full_n;
      if (f === v)
        return;
    end
    n_errors++;
    $display("mismatch at %0t: flag %0d stuck", $time, sel);
    final_report();
  endtask

  // strap held through reset; flags and output word checked after
  task automatic do_reset(input logic strap);
    @(posedge clk_in);
    #1;
    reset_in = 1'b1;
    partner_inst.write_enable_b_or_load_n_out = strap;
    repeat (5) @(posedge read_clk_in);
    @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    partner_inst.write_enable_b_or_load_n_out = 1'b1;
    repeat (4) @(posedge read_clk_in);
    #1;
    check({5'h00, empty_n, near_empty_n, full_n, near_full_n}, 9'h003);
    check(rd_word, 9'h000);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_flow();
    word_t w;
    partner_inst.push(7, 9'h1A5);
    wait_flag(0, 1'b1);
    repeat (8) @(posedge read_clk_in);
    check({8'h00, near_empty_n}, 9'h000);
    partner_inst.push(1, 9'h1AC);
    wait_flag(2, 1'b1);
    partner_inst.pull(1'b1, w);
    check(w, 9'h000);
    for (int i = 0; i < 8; i++)
    begin
      partner_inst.pull(1'b0, w);
      check(w, 9'h1A5 + word_t'(i));
    end
    wait_flag(0, 1'b0);
    check({8'h00, near_empty_n}, 9'h000);
    partner_inst.pull(1'b0, w);
    check(w, 9'h1AC);
  endtask

  task automatic t_oe();
    @(posedge clk_in);
    #1;
    partner_inst.output_enable_n_out = 1'b1;
    repeat (4) @(posedge read_clk_in);
    #1;
    check({8'h00, rd_oe_n}, 9'h001);
    partner_inst.output_enable_n_out = 1'b0;
    repeat (4) @(posedge read_clk_in);
    #1;
    check({8'h00, rd_oe_n}, 9'h000);
  endtask

  // filling the whole depth costs about 16k write clocks
  task automatic t_full();
    word_t w;
    partner_inst.push(16376, 9'h000);
    repeat (12) @(posedge clk_in);
    check({7'h00, full_n, near_full_n}, 9'h003);
    partner_inst.push(1, 9'h0F8);
    wait_flag(3, 1'b0);
    partner_inst.push(7, 9'h0F9);
    wait_flag(1, 1'b0);
    partner_inst.push(3, 9'h155);
    partner_inst.pull(1'b0, w);
    check(w, 9'h000);
    wait_flag(1, 1'b1);
    check({8'h00, near_full_n}, 9'h000);
    partner_inst.push(1, 9'h000);
    wait_flag(1, 1'b0);
  endtask

  task automatic t_offsets();
    word_t w;
    word_t exp [5] = '{9'h002, 9'h000, 9'h1F0, 9'h003, 9'h002};
    for (int i = 0; i < 4; i++)
      partner_inst.load(exp[i]);
    repeat (6) @(posedge read_clk_in);
    @(posedge clk_in);
    #1;
    partner_inst.write_enable_b_or_load_n_out = 1'b0;
    repeat (3) @(posedge read_clk_in);
    for (int i = 0; i < 5; i++)
    begin
      partner_inst.pull(1'b0, w);
      check(w, exp[i]);
    end
    @(posedge clk_in);
    #1;
    partner_inst.write_enable_b_or_load_n_out = 1'b1;
    partner_inst.push(3, 9'h0AA);
    wait_flag(2, 1'b1);
    partner_inst.pull(1'b0, w);
    check(w, 9'h0AA);
    wait_flag(2, 1'b0);
  endtask

  // main sequence
  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    // held from time zero so write-clock flops and checks start in reset
    reset_in = 1'b1;
    do_reset(1'b1);
    t_flow();
    t_oe();
    t_full();
    do_reset(1'b0);
    t_offsets();
    final_report();
  end
endmodule
